// >>> verification/pulse_load.sv
`timescale 1ns/10ps
`default_nettype none

module pulse_load (
	// clock and observed pins
	input  wire logic        clk,
	input  wire logic [3:0]  pin,
	// restarts the width statistics
	input  wire logic        clr,
	// measurements in clk cycles
	output logic [31:0]      rise_t [4],
	output logic [31:0]      period [4],
	output logic [31:0]      wmin [4],
	output logic [31:0]      wmax [4]
);
	logic [31:0] now = '0;
	logic [3:0]  last;

	// a load only sees levels: time rises, high widths and periods
	always @(posedge clk) begin
		now <= now + 32'h1;
		last <= pin;
		for (int i = 0; i < 4; i++) begin
			// rises are tracked even while the statistics restart
			if (pin[i] && !last[i]) begin
				rise_t[i] <= now;
				period[i] <= now - rise_t[i];
			end
			if (clr) begin
				wmin[i] <= 32'hFFFFFFFF;
				wmax[i] <= 32'h0;
			end else if (!pin[i] && last[i]) begin
				if (now - rise_t[i] < wmin[i])
					wmin[i] <= now - rise_t[i];
				if (now - rise_t[i] > wmax[i])
					wmax[i] <= now - rise_t[i];
			end
		end
	end
endmodule

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pulse_timer_defs.svh"

module tb;
	logic                      clk;
	logic                      rst;
	logic                      clr;
	logic                      rd_d = 1'b0;
	pulse_timer_pkg::reg_req_s req;
	logic [31:0]               rdata;
	logic [3:0]                pins;
	logic [31:0]               rise_t [4];
	logic [31:0]               period [4];
	logic [31:0]               wmin [4];
	logic [31:0]               wmax [4];
	logic [31:0]               exp_q [$];
	logic [7:0]                adr_q [$];
	logic [31:0]               seed = 32'h15;
	logic [31:0]               v;
	int                        err_count = 0;
	int                        checks_done = 0;
	int                        cycles = 0;

	dual_unit_pulse_pattern_timer DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .pulse_output_pin(pins));
	pulse_load load (.clk(clk), .pin(pins), .clr(clr), .rise_t(rise_t), .period(period), .wmin(wmin), .wmax(wmax));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// one strobe cycle, then a quiet cycle so no signal is set twice per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		req.addr <= a;
		req.rd <= 1'b1;
		exp_q.push_back(e);
		adr_q.push_back(a);
		@(posedge clk);
		req.rd <= 1'b0;
		@(posedge clk);
	endtask

	// both channels get the same edges; cp2 and cp4 carry no dither rate
	task automatic cfg_unit(input logic u, input logic [31:0] mode, input logic [15:0] c0, c1, c2);
		logic [7:0] b;
		b = u ? `PT_UNIT_SPAN : 8'h00;
		wr(b + `PT_OFS_MODE, mode);
		wr(b + `PT_OFS_CTRL, 32'h0);
		wr(b + `PT_OFS_STG, {16'h0, c0});
		wr(b + `PT_OFS_STG + 8'h04, {16'h0, c1});
		wr(b + `PT_OFS_STG + 8'h08, {12'h0, c2, 4'h0});
		wr(b + `PT_OFS_STG + 8'h0C, {16'h0, c1});
		wr(b + `PT_OFS_STG + 8'h10, {12'h0, c2, 4'h0});
	endtask

	// stale widths are dropped before the window that is judged
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	// ----------------------------------------
	// clock, timeout and read monitor
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (rd_d)
			check($sformatf("read %h", adr_q.pop_front()), rdata, exp_q.pop_front());
		rd_d <= req.rd;
		if (cycles == 75000) begin
			err_count++;
			final_report();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		req = '0;
		clr = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`PT_OFS_RUN, 32'h0);
		rd(`PT_OFS_CNT0, 32'h0);
		check("pins", {28'h0, pins}, 32'h0);
		$display("test reset done");

		for (int u = 0; u < 2; u++) begin
			for (int m = 0; m < 6; m++) begin
				v = rnd();
				wr(8'(u * 64 + 16 + m * 4), v);
				wr(8'(u * 64 + 40 + m * 4), rnd());
				v = v & ((m == 5) ? ((u == 0) ? `PT_MASK_PHASE : 20'h0) :
					(m == 2 || m == 4) ? `PT_MASK_DITH : `PT_MASK_PLAIN);
				rd(8'(u * 64 + 40 + m * 4), v);
			end
		end
		wr(8'hC0, rnd());
		rd(8'hC0, 32'h0);
		$display("test compare load done");

		cfg_unit(1'b0, 32'h12, 16'h9, 16'h2, 16'h5);
		cfg_unit(1'b1, 32'h10, 16'h4, 16'h0, 16'h2);
		wr(`PT_OFS_RUN, 32'h1);
		wr(`PT_UNIT_SPAN + `PT_OFS_RUN, 32'h1);
		settle(100);
		check("period a0", period[0], 32'd40);
		check("width a0", wmax[0], 32'd12);
		check("width b0", wmin[1], 32'd12);
		check("period a1", period[2], 32'd5);
		check("width a1", wmax[2], 32'd2);
		$display("test pulse done");

		wr(`PT_OFS_MODE, 32'h32);
		settle(100);
		check("inverted a0", wmax[0], 32'd28);
		check("plain b0", wmax[1], 32'd12);
		$display("test polarity done");

		wr(`PT_UNIT_SPAN + `PT_OFS_CTRL, 32'h8);
		wr(`PT_UNIT_SPAN + `PT_OFS_STG + 8'h08, 32'h21);
		settle(200);
		check("narrow a1", wmin[2], 32'd2);
		check("wide a1", wmax[2], 32'd3);
		wr(`PT_OFS_CFG, 32'h2);
		settle(100);
		check("no dither a1", wmax[2], 32'd2);
		wr(`PT_OFS_CFG, 32'h0);
		$display("test dither done");

		wr(`PT_OFS_RUN, 32'h0);
		repeat (2) @(posedge clk);
		rd(`PT_OFS_CNT0, 32'h0);
		check("idle a0", {31'h0, pins[0]}, 32'h1);
		check("idle b0", {31'h0, pins[1]}, 32'h0);
		$display("test stop done");

		wr(`PT_OFS_CTRL, 32'h1);
		wr(`PT_OFS_RUN, 32'h1);
		wr(`PT_OFS_STG + 8'h04, 32'h3);
		rd(`PT_OFS_ACT + 8'h04, 32'h2);
		wr(`PT_OFS_UPD, 32'h1);
		repeat (60) @(posedge clk);
		rd(`PT_OFS_ACT + 8'h04, 32'h3);
		rd(`PT_OFS_UPD, 32'h0);
		$display("test buffered done");

		wr(`PT_OFS_RUN, 32'h0);
		wr(`PT_UNIT_SPAN + `PT_OFS_RUN, 32'h0);
		wr(`PT_OFS_CFG, 32'h1);
		cfg_unit(1'b0, 32'h10, 16'd19, 16'h2, 16'h5);
		wr(`PT_OFS_STG + 8'h14, 32'h7);
		cfg_unit(1'b1, 32'h03, 16'h3, 16'h2, 16'h5);
		wr(`PT_UNIT_SPAN + `PT_OFS_RUN, 32'h1);
		wr(`PT_OFS_RUN, 32'h1);
		settle(150);
		check("period a1", period[2], 32'd20);
		check("width a1", wmax[2], 32'd3);
		check("phase", (rise_t[2] + 32'd40 - rise_t[0]) % 32'd20, 32'd8);
		$display("test interlock done");

		wr(`PT_OFS_RUN, 32'h0);
		wr(`PT_OFS_CFG, 32'h0);
		cfg_unit(1'b0, 32'h00, 16'h9, 16'h2, 16'h5);
		wr(`PT_OFS_RUN, 32'h1);
		repeat (65600) @(posedge clk);
		check("free period", period[0], 32'd65536);
		$display("test free run done");
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule

`default_nettype wire

// >>> verilog/dual_unit_pulse_pattern_timer.sv
// Operation
// - per-unit prescaled clock from 4-bit select
// - interlock: unit one uses unit zero clock
// - unit zero: counter, six comparators, two channels
// - unit one: counter, five comparators, two channels
// - counter increments once per prescaled clock
// - run bit zero clears, one starts
// - clear-on-match off: counter runs free
// - clear-on-match on: clear at cycle comparator
// - interlock: unit one clears on phase match
// - units may run interlocked by phase comparator
// - phase comparator sets offset between units
// - phase match uses 17-bit compare value
// - unbuffered: staging write loads active register
// - active registers read-only to software
// - buffered: transfer at update point when enabled
// - comparators two, four hold twenty bits
// - dithered trailing match delayed one clock
// - dither only in pulse and interlock modes
// - channel a: lead cmp1, trail cmp2
// - channel b leads on comparator three
// - trailing edges on comparators two, four
// - one polarity bit per channel
// - polarity zero: lead high, trail low
// - pulse mode: units run independently
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "pulse_timer_defs.svh"

module dual_unit_pulse_pattern_timer #(
	parameter int NUM_CMP0 = 6,
	parameter int NUM_CMP1 = 5
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// register port
	input  wire pulse_timer_pkg::reg_req_s req,
	output logic [31:0]                    rdata,
	// pulse outputs: unit0 a/b, unit1 a/b
	output logic [3:0]                     pulse_output_pin
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------

	// prescaled tick: divide by two to the power of the select
	function automatic logic prescale_tick(input logic [15:0] p, input logic [3:0] sel);
		logic [15:0] m;
		m = 16'((17'h00001 << sel) - 17'h00001);
		return (p & m) == m;
	endfunction

	// implemented bits of each compare register
	function automatic logic [19:0] cmp_mask(input int m);
		if (m == `PT_CMP_TRAIL_A || m == `PT_CMP_TRAIL_B) begin
			return `PT_MASK_DITH;
		end
		else if (m == `PT_CMP_PHASE) begin
			return `PT_MASK_PHASE;
		end
		return `PT_MASK_PLAIN;
	endfunction

	// 16-bit compare value; dither comparators keep it above the rate
	function automatic logic [15:0] cmp_val(input logic [19:0] a, input int m);
		if (m == `PT_CMP_TRAIL_A || m == `PT_CMP_TRAIL_B) begin
			return a[19:4];
		end
		return a[15:0];
	endfunction

	// widen this period when its index within the dither cycle is below the rate
	function automatic logic widen(input logic [3:0] per, input logic [2:0] dcy, input logic [3:0] rate);
		logic [3:0] pm;
		pm = 4'((8'h01 << dcy) - 8'h01);
		return (dcy != 3'h0) && ((per & pm) < rate);
	endfunction

	function automatic int num_cmp(input int n);
		return (n == 0) ? NUM_CMP0 : NUM_CMP1;
	endfunction

	// ----------------------------------------
	// state and decode
	// ----------------------------------------

	pulse_timer_pkg::state_s st_reg;
	pulse_timer_pkg::state_s st_next;

	logic [1:0]      tick;
	logic [1:0][5:0] match;
	logic [1:0]      clr;
	logic [1:0]      cyc_end;
	logic [1:0]      xfer;
	logic            interlock;
	logic            dith_on;
	logic [7:0]      loc;
	int              un;

	assign rdata            = st_reg.rdata;
	assign pulse_output_pin = {st_reg.u[1].pin, st_reg.u[0].pin};

	// next-state logic for both units and the register port
	always_comb begin
		st_next   = st_reg;
		interlock = st_reg.mode == pulse_timer_pkg::MODE_INTERLOCK;
		dith_on   = st_reg.mode == pulse_timer_pkg::MODE_PPG || interlock;
		un        = (req.addr >= `PT_UNIT_SPAN) ? 1 : 0;
		loc       = (un == 1) ? req.addr - `PT_UNIT_SPAN : req.addr;
		tick      = '0;
		match     = '0;
		clr       = '0;
		cyc_end   = '0;
		xfer      = '0;
		st_next.presc = st_reg.presc + 16'h0001;
		st_next.rdata = 32'h0;

		for (int n = 0; n < 2; n++) begin
			tick[n] = prescale_tick(st_reg.presc, st_reg.u[n].clksel);
			if (n == 1 && interlock) begin
				tick[n] = tick[0];
			end
			for (int m = 0; m < 6; m++) begin
				if (m < num_cmp(n) && m != `PT_CMP_PHASE) begin
					match[n][m] = st_reg.u[n].run && tick[n] && st_reg.u[n].cnt == cmp_val(st_reg.u[n].act[m], m);
				end
			end
			if (num_cmp(n) > `PT_CMP_PHASE) begin
				match[n][`PT_CMP_PHASE] = st_reg.u[n].run && tick[n] &&
					{1'b0, st_reg.u[n].cnt} == st_reg.u[n].act[`PT_CMP_PHASE][16:0];
			end
		end

		for (int n = 0; n < 2; n++) begin
			if (n == 1 && interlock) begin
				clr[n] = match[0][`PT_CMP_PHASE];
			end
			else begin
				clr[n] = st_reg.u[n].clr_en && match[n][`PT_CMP_CYCLE];
			end
			cyc_end[n] = clr[n] || (st_reg.u[n].run && tick[n] && st_reg.u[n].cnt == `PT_CNT_MAX);

			if (!st_reg.u[n].run) begin
				st_next.u[n].cnt = 16'h0000;
			end
			else if (clr[n]) begin
				st_next.u[n].cnt = 16'h0000;
			end
			else if (tick[n]) begin
				st_next.u[n].cnt = st_reg.u[n].cnt + 16'h0001;
			end

			// period index steps the dither cycle
			if (!st_reg.u[n].run) begin
				st_next.u[n].per_idx = 4'h0;
			end
			else if (cyc_end[n]) begin
				st_next.u[n].per_idx = st_reg.u[n].per_idx + 4'h1;
			end

			for (int c = 0; c < 2; c++) begin
				logic lead;
				logic tm;
				logic trail;
				logic wid;
				int   li;
				int   ti;
				li    = (c == 0) ? `PT_CMP_LEAD_A : `PT_CMP_LEAD_B;
				ti    = (c == 0) ? `PT_CMP_TRAIL_A : `PT_CMP_TRAIL_B;
				lead  = match[n][li];
				tm    = match[n][ti];
				wid   = dith_on && widen(st_reg.u[n].per_idx, st_reg.u[n].dcy[c], st_reg.u[n].act[ti][3:0]);
				trail = wid ? (st_reg.u[n].dly[c] && tick[n]) : tm;
				if (!st_reg.u[n].run) begin
					st_next.u[n].dly[c] = 1'b0;
				end
				else if (tick[n]) begin
					st_next.u[n].dly[c] = wid && tm;
				end
				if (!st_reg.u[n].run) begin
					st_next.u[n].lvl[c] = 1'b0;
				end
				else if (trail) begin
					st_next.u[n].lvl[c] = 1'b0;
				end
				else if (lead) begin
					st_next.u[n].lvl[c] = 1'b1;
				end
			end

			// buffered transfer at the period end
			xfer[n] = st_reg.u[n].buf_mode && st_reg.u[n].upd && cyc_end[n];
			if (xfer[n]) begin
				st_next.u[n].act = st_reg.u[n].stg;
				st_next.u[n].upd = 1'b0;
			end
		end

		// software writes; flag set wins over the transfer clear
		if (req.wr) begin
			if (req.addr == `PT_OFS_CFG) begin
				st_next.mode = pulse_timer_pkg::op_mode_e'(req.wdata[1:0]);
			end
			else if (req.addr < `PT_OFS_CFG) begin
				if (loc == `PT_OFS_MODE) begin
					st_next.u[un].clksel = req.wdata[3:0];
					st_next.u[un].clr_en = req.wdata[`PT_MODE_CLR];
					st_next.u[un].pol = req.wdata[`PT_MODE_POLA +: 2];
				end
				if (loc == `PT_OFS_RUN) begin
					st_next.u[un].run = req.wdata[0];
					// stop clears at once
					// a stale count or level would otherwise show for one cycle
					if (!req.wdata[0]) begin
						st_next.u[un].cnt     = 16'h0000;
						st_next.u[un].per_idx = 4'h0;
						st_next.u[un].dly     = 2'b00;
						st_next.u[un].lvl     = 2'b00;
					end
				end
				if (loc == `PT_OFS_CTRL) begin
					st_next.u[un].buf_mode = req.wdata[`PT_CTRL_BUF];
					st_next.u[un].dcy[0]   = req.wdata[`PT_CTRL_DCYA +: `PT_DCY_W];
					st_next.u[un].dcy[1]   = req.wdata[`PT_CTRL_DCYB +: `PT_DCY_W];
				end
				if (loc == `PT_OFS_UPD && req.wdata[0]) begin
					st_next.u[un].upd = 1'b1;
				end
				for (int m = 0; m < 6; m++) begin
					if (m < num_cmp(un) && loc == `PT_OFS_STG + 8'(m) * `PT_WORD) begin
						st_next.u[un].stg[m] = req.wdata[19:0] & cmp_mask(m);
						if (!st_reg.u[un].buf_mode) begin
							st_next.u[un].act[m] = req.wdata[19:0] & cmp_mask(m);
						end
					end
				end
			end
		end

		// read data, valid in the following cycle only
		if (req.rd) begin
			if (req.addr == `PT_OFS_CFG) begin
				st_next.rdata = {30'h0, st_reg.mode};
			end
			else if (req.addr == `PT_OFS_CNT0) begin
				st_next.rdata = {16'h0, st_reg.u[0].cnt};
			end
			else if (req.addr == `PT_OFS_CNT1) begin
				st_next.rdata = {16'h0, st_reg.u[1].cnt};
			end
			else if (req.addr < `PT_OFS_CFG) begin
				if (loc == `PT_OFS_MODE) begin
					st_next.rdata = {25'h0, st_reg.u[un].pol, st_reg.u[un].clr_en, st_reg.u[un].clksel};
				end
				if (loc == `PT_OFS_RUN) begin
					st_next.rdata = {31'h0, st_reg.u[un].run};
				end
				if (loc == `PT_OFS_CTRL) begin
					st_next.rdata = {25'h0, st_reg.u[un].dcy[1], st_reg.u[un].dcy[0], st_reg.u[un].buf_mode};
				end
				if (loc == `PT_OFS_UPD) begin
					st_next.rdata = {31'h0, st_reg.u[un].upd};
				end
				for (int m = 0; m < 6; m++) begin
					if (m < num_cmp(un) && loc == `PT_OFS_STG + 8'(m) * `PT_WORD) begin
						st_next.rdata = {12'h0, st_reg.u[un].stg[m]};
					end
					if (m < num_cmp(un) && loc == `PT_OFS_ACT + 8'(m) * `PT_WORD) begin
						st_next.rdata = {12'h0, st_reg.u[un].act[m]};
					end
				end
			end
		end

		// pins from level and polarity, so a stop shows the inactive level
		for (int n = 0; n < 2; n++) begin
			st_next.u[n].pin = st_next.u[n].lvl ^ st_next.u[n].pol;
		end
	end

	// single state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end
		else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_stop_clear;
		!st_reg.u[0].run |-> st_reg.u[0].cnt == 16'h0000;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not zero");

	property p_count_up;
		st_reg.u[0].run && tick[0] && !clr[0] && req.addr != `PT_OFS_RUN
			|=> st_reg.u[0].cnt == 16'($past(st_reg.u[0].cnt) + 16'h0001);
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not step by one");

	property p_hold_no_tick;
		st_reg.u[0].run && !tick[0] && req.addr != `PT_OFS_RUN |=> $stable(st_reg.u[0].cnt);
	endproperty
	a_hold_no_tick: assert property (p_hold_no_tick) else $error("counter moved without tick");

	property p_cycle_clear;
		!interlock && st_reg.u[0].clr_en && match[0][`PT_CMP_CYCLE] |=> st_reg.u[0].cnt == 16'h0000;
	endproperty
	a_cycle_clear: assert property (p_cycle_clear) else $error("no clear on cycle match");

	property p_phase_clear;
		interlock && st_reg.u[1].run && match[0][`PT_CMP_PHASE] |=> st_reg.u[1].cnt == 16'h0000;
	endproperty
	a_phase_clear: assert property (p_phase_clear) else $error("unit one not cleared on phase match");

	property p_il_clock;
		interlock |-> tick[1] == tick[0];
	endproperty
	a_il_clock: assert property (p_il_clock) else $error("interlocked clock differs");

	property p_write_through;
		req.wr && req.addr == `PT_OFS_STG + `PT_WORD && !st_reg.u[0].buf_mode
			|=> st_reg.u[0].act[1] == ($past(req.wdata[19:0]) & `PT_MASK_PLAIN);
	endproperty
	a_write_through: assert property (p_write_through) else $error("active not loaded on write");

	property p_buffered_hold;
		st_reg.u[0].buf_mode && !xfer[0] |=> $stable(st_reg.u[0].act);
	endproperty
	a_buffered_hold: assert property (p_buffered_hold) else $error("buffered active changed early");

	property p_stop_level;
		!st_reg.u[0].run |-> st_reg.u[0].pin == st_reg.u[0].pol;
	endproperty
	a_stop_level: assert property (p_stop_level) else $error("stopped output not inactive");

	property p_lead_edge;
		match[0][`PT_CMP_LEAD_A] && !match[0][`PT_CMP_TRAIL_A] && !st_reg.u[0].dly[0]
			&& req.addr != `PT_OFS_RUN && req.addr != `PT_OFS_MODE
			|=> st_reg.u[0].pin[0] == !st_reg.u[0].pol[0];
	endproperty
	a_lead_edge: assert property (p_lead_edge) else $error("leading edge missing");

	c_wrap: cover property (st_reg.u[0].cnt == `PT_CNT_MAX ##1 st_reg.u[0].cnt == 16'h0000);
	c_dither: cover property (st_reg.u[1].dly[0] ##1 !st_reg.u[1].pin[0]);
	c_interlock: cover property (interlock && match[0][`PT_CMP_PHASE]);
	c_xfer: cover property (xfer[0]);

endmodule

`default_nettype wire

// >>> verilog/pulse_timer_defs.svh
`ifndef PULSE_TIMER_DEFS_SVH
`define PULSE_TIMER_DEFS_SVH
// ----------------------------------------
// register map (byte offsets)
// ----------------------------------------
`define PT_UNIT_SPAN   8'h40
`define PT_OFS_MODE    8'h00
`define PT_OFS_RUN     8'h04
`define PT_OFS_CTRL    8'h08
`define PT_OFS_UPD     8'h0C
`define PT_OFS_STG     8'h10
`define PT_OFS_ACT     8'h28
`define PT_OFS_CFG     8'h80
`define PT_OFS_CNT0    8'h84
`define PT_OFS_CNT1    8'h88
`define PT_WORD        8'h04
// ----------------------------------------
// field positions
// ----------------------------------------
`define PT_MODE_CLR    4
`define PT_MODE_POLA   5
`define PT_CTRL_BUF    0
`define PT_CTRL_DCYA   1
`define PT_CTRL_DCYB   4
`define PT_DCY_W       3
// ----------------------------------------
// comparator roles and widths
// ----------------------------------------
`define PT_CMP_CYCLE   0
`define PT_CMP_LEAD_A  1
`define PT_CMP_TRAIL_A 2
`define PT_CMP_LEAD_B  3
`define PT_CMP_TRAIL_B 4
`define PT_CMP_PHASE   5
`define PT_MASK_DITH   20'hFFFFF
`define PT_MASK_PHASE  20'h1FFFF
`define PT_MASK_PLAIN  20'h0FFFF
`define PT_CNT_MAX     16'hFFFF
`endif

// >>> verilog/pulse_timer_pkg.sv
package pulse_timer_pkg;
	// register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

	// operating mode of the pair of units
	typedef enum logic [1:0] {
		MODE_PPG,
		MODE_INTERLOCK,
		MODE_RSV2,
		MODE_RSV3
	} op_mode_e;

	// one timer unit
	typedef struct packed {
		logic [15:0]      cnt;
		logic [5:0][19:0] stg;
		logic [5:0][19:0] act;
		logic [3:0]       clksel;
		logic             clr_en;
		logic             run;
		logic             buf_mode;
		logic             upd;
		logic [1:0]       pol;
		logic [1:0][2:0]  dcy;
		logic [3:0]       per_idx;
		logic [1:0]       dly;
		logic [1:0]       lvl;
		logic [1:0]       pin;
	} unit_s;

	// whole block state
	typedef struct packed {
		unit_s [1:0] u;
		logic [15:0] presc;
		op_mode_e    mode;
		logic [31:0] rdata;
	} state_s;
endpackage
